// [rtl/serial_port_pkg.sv]
// Constants and types shared by the serial port design
package serial_port_pkg;
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_POWER_CONTROL = 10'h087;
  localparam logic [9:0] IDX_SERIAL_CONTROL = 10'h098;
  localparam logic [9:0] IDX_SERIAL_DATA = 10'h099;
  localparam logic [9:0] IDX_PORT_CONFIG = 10'h0a0;
  localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
  localparam int SC_RI = 0;
  localparam int SC_TI = 1;
  localparam int SC_RB8 = 2;
  localparam int SC_TB8 = 3;
  localparam int SC_REN = 4;
  localparam int SC_SM2 = 5;
  localparam int PC_BAUD_DOUBLE = 7;
  localparam int CFG_SIX = 0;
  localparam int CFG_T2 = 1;
  localparam int CFG_IE = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  // Divisors give the tick rate: half bits in mode 0, 16x oversampling else
  localparam logic [3:0] DIV_M0_12T = 4'h6;
  localparam logic [3:0] DIV_M0_6T = 4'h3;
  localparam logic [3:0] DIV_M2_12T = 4'h4;
  localparam logic [3:0] DIV_M2_12T_DBL = 4'h2;
  localparam logic [3:0] DIV_M2_6T = 4'h2;
  localparam logic [3:0] DIV_M2_6T_DBL = 4'h1;
  localparam logic [3:0] DIV_T1 = 4'h2;
  localparam logic [3:0] DIV_T1_DBL = 4'h1;
  localparam logic [3:0] DIV_T2 = 4'h1;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] LEN_10 = 4'ha;
  localparam logic [3:0] LEN_11 = 4'hb;
  localparam logic [3:0] M0_LAST = 4'h7;
  localparam logic [3:0] RX_LAST = 4'h8;

  typedef enum logic [1:0] {
    MODE_SYNC = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_FIXED9 = 2'b10,
    MODE_TIMED9 = 2'b11
  } mode_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10
  } rx_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
endpackage

// [rtl/baud_tick.sv]
// Tick divider for the serial port bit timing
`timescale 1ns/100ps
module baud_tick #(
  parameter int DIV_W = 4
) (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic src_pulse,
  input logic [DIV_W-1:0] divisor,
  output logic tick
);
  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic tick;
  } tick_state_type;

  tick_state_type st;
  tick_state_type next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (src_pulse) begin
      // Counter above a freshly lowered divisor wraps at once
      if (st.count >= divisor - 1'b1) begin
        next_st.count = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule // baud_tick

// [rtl/serial_port.sv]
// Serial port: sync shift mode and three UART modes behind an APB slave
`timescale 1ns/100ps
module serial_port (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input serial_port_pkg::apb_req_type apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input logic timer1_overflow,
  input logic timer2_overflow,
  input logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  output logic serial_irq
);
  import serial_port_pkg::*;

  typedef struct packed {
    logic [7:0] serial_control;
    logic baud_double;
    logic [2:0] cfg;
    logic tx_busy;
    logic [10:0] tx_shift;
    logic [3:0] tx_cnt;
    logic [3:0] tx_sub;
    logic [3:0] tx_len;
    logic m0_busy;
    logic m0_rx;
    logic m0_half;
    logic m0_bit;
    logic [3:0] m0_cnt;
    logic [7:0] m0_shift;
    rx_state_type rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_cnt;
    logic [8:0] rx_shift;
    logic [7:0] rx_serial_data_buffer;
    logic rxd_prev;
    logic ren_prev;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } port_state_type;

  port_state_type st;
  port_state_type next_st;
  mode_type mode;
  logic tick;
  logic src_pulse;
  logic [3:0] divisor;
  logic access;
  logic done;
  logic wr;
  logic [9:0] idx;
  logic wr_serial_control;
  logic wr_serial_data_buffer;
  logic rx_final;
  logic rx_load;
  logic m0_end;

  assign mode = mode_type'(st.serial_control[7:6]);
  assign access = apb_req.psel && apb_req.penable;
  assign done = access && st.pready;
  assign wr = done && apb_req.pwrite;
  assign idx = apb_req.paddr[ADDR_W-1:2];
  assign wr_serial_control = wr && (idx == IDX_SERIAL_CONTROL);
  assign wr_serial_data_buffer = wr && (idx == IDX_SERIAL_DATA);
  assign rx_final = tick && (st.rx_state == RX_DATA)
    && (st.rx_sub == OVS_LAST) && (st.rx_cnt == RX_LAST);
  // Buffer full or filter failing drops the frame
  assign rx_load = rx_final && !st.serial_control[SC_RI] && st.serial_control[SC_REN]
    && (!st.serial_control[SC_SM2] || rxd_in);
  assign m0_end = tick && st.m0_busy && st.m0_half && (st.m0_cnt == M0_LAST);

  // Rate source and divisor per mode
  always_comb begin
    src_pulse = 1'b1;
    divisor = DIV_M0_12T;
    unique case (mode)
      MODE_SYNC: begin
        divisor = st.cfg[CFG_SIX] ? DIV_M0_6T : DIV_M0_12T;
      end
      MODE_FIXED9: begin
        if (st.cfg[CFG_SIX]) begin
          divisor = st.baud_double ? DIV_M2_6T_DBL : DIV_M2_6T;
        end else begin
          divisor = st.baud_double ? DIV_M2_12T_DBL : DIV_M2_12T;
        end
      end
      MODE_UART8, MODE_TIMED9: begin
        if (st.cfg[CFG_T2]) begin
          src_pulse = timer2_overflow;
          divisor = DIV_T2;
        end else begin
          src_pulse = timer1_overflow;
          divisor = st.baud_double ? DIV_T1_DBL : DIV_T1;
        end
      end
    endcase
  end

  baud_tick #(
    .DIV_W(4)
  ) u_baud_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .src_pulse(src_pulse),
    .divisor(divisor),
    .tick(tick)
  );

  always_comb begin
    next_st = st;
    next_st.rxd_prev = rxd_in;
    next_st.ren_prev = st.serial_control[SC_REN];

    // APB slave: one wait state, answer latched with pready
    next_st.pready = access && !st.pready;
    if (access && !st.pready) begin
      next_st.pslverr = 1'b0;
      unique case (idx)
        IDX_POWER_CONTROL: next_st.prdata = {24'h000000, st.baud_double, 7'h00};
        IDX_SERIAL_CONTROL: next_st.prdata = {24'h000000, st.serial_control};
        IDX_SERIAL_DATA: next_st.prdata = {24'h000000, st.rx_serial_data_buffer};
        IDX_PORT_CONFIG: next_st.prdata = {29'h00000000, st.cfg};
        default: begin
          next_st.prdata = 32'h00000000;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_serial_control) begin
      next_st.serial_control = apb_req.pwdata[7:0];
    end
    if (wr && idx == IDX_POWER_CONTROL) begin
      next_st.baud_double = apb_req.pwdata[PC_BAUD_DOUBLE];
    end
    if (wr && idx == IDX_PORT_CONFIG) begin
      next_st.cfg = apb_req.pwdata[2:0];
    end

    // Asynchronous transmitter
    if (st.tx_busy && tick) begin
      next_st.tx_sub = st.tx_sub + 1'b1;
      if (st.tx_sub == OVS_LAST) begin
        next_st.tx_cnt = st.tx_cnt + 1'b1;
        next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
        if (st.tx_cnt == st.tx_len - 1'b1) begin
          next_st.tx_busy = 1'b0;
          next_st.serial_control[SC_TI] = 1'b1;
        end
      end
    end

    // Mode 0 shifter: clock low half with sampling, then high half with shifting
    if (st.m0_busy && tick) begin
      next_st.m0_half = !st.m0_half;
      if (!st.m0_half) begin
        next_st.m0_bit = rxd_in;
      end else begin
        next_st.m0_shift = {st.m0_rx ? st.m0_bit : 1'b0,
          st.m0_shift[7:1]};
        next_st.m0_cnt = st.m0_cnt + 1'b1;
        if (m0_end) begin
          next_st.m0_busy = 1'b0;
          if (st.m0_rx) begin
            next_st.rx_serial_data_buffer = {st.m0_bit, st.m0_shift[7:1]};
            next_st.serial_control[SC_RI] = 1'b1;
          end else begin
            next_st.serial_control[SC_TI] = 1'b1;
          end
        end
      end
    end
    if (mode == MODE_SYNC && st.serial_control[SC_REN] && !st.ren_prev
        && !st.serial_control[SC_RI] && !st.m0_busy && !wr_serial_data_buffer) begin
      next_st.m0_busy = 1'b1;
      next_st.m0_rx = 1'b1;
      next_st.m0_half = 1'b0;
      next_st.m0_cnt = 4'h0;
    end

    // Asynchronous receiver, free of the transmitter
    unique case (st.rx_state)
      RX_IDLE: begin
        if (mode != MODE_SYNC && st.serial_control[SC_REN] && st.rxd_prev
            && !rxd_in) begin
          next_st.rx_state = RX_START;
          next_st.rx_sub = 4'h0;
        end
      end
      RX_START: begin
        if (tick) begin
          next_st.rx_sub = st.rx_sub + 1'b1;
          if (st.rx_sub == OVS_MID) begin
            // A glitch shorter than half a bit is not a start
            next_st.rx_state = rxd_in ? RX_IDLE : RX_DATA;
            next_st.rx_sub = 4'h0;
            next_st.rx_cnt = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          next_st.rx_sub = st.rx_sub + 1'b1;
          if (st.rx_sub == OVS_LAST) begin
            next_st.rx_shift = {rxd_in, st.rx_shift[8:1]};
            next_st.rx_cnt = st.rx_cnt + 1'b1;
            if (st.rx_cnt == RX_LAST) begin
              next_st.rx_state = RX_IDLE;
            end
          end
        end
      end
      default: next_st.rx_state = RX_IDLE;
    endcase
    if (rx_load) begin
      // Holding register is separate from the shifter
      next_st.rx_serial_data_buffer = st.rx_shift[8:1];
      next_st.serial_control[SC_RB8] = rxd_in;
      next_st.serial_control[SC_RI] = 1'b1;
    end
    if (!st.serial_control[SC_REN] || mode == MODE_SYNC) begin
      next_st.rx_state = RX_IDLE;
    end

    // Writing the data buffer always restarts the transmitter
    if (wr_serial_data_buffer) begin
      if (mode == MODE_SYNC) begin
        next_st.m0_busy = 1'b1;
        next_st.m0_rx = 1'b0;
        next_st.m0_half = 1'b0;
        next_st.m0_cnt = 4'h0;
        next_st.m0_shift = apb_req.pwdata[7:0];
      end else begin
        next_st.tx_busy = 1'b1;
        next_st.tx_cnt = 4'h0;
        next_st.tx_sub = 4'h0;
        if (mode == MODE_UART8) begin
          next_st.tx_shift = {2'b11, apb_req.pwdata[7:0], 1'b0};
          next_st.tx_len = LEN_10;
        end else begin
          next_st.tx_shift = {1'b1, st.serial_control[SC_TB8],
            apb_req.pwdata[7:0], 1'b0};
          next_st.tx_len = LEN_11;
        end
      end
    end

    // Pins: sync mode outranks a stale async frame
    if (next_st.m0_busy) begin
      next_st.txd = next_st.m0_half;
    end else if (next_st.tx_busy) begin
      next_st.txd = next_st.tx_shift[0];
    end else begin
      next_st.txd = 1'b1;
    end
    next_st.rxd_out = next_st.m0_shift[0];
    next_st.rxd_oe = next_st.m0_busy && !next_st.m0_rx;
    next_st.irq = next_st.cfg[CFG_IE]
      && (next_st.serial_control[SC_TI] || next_st.serial_control[SC_RI]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.serial_control <= SERIAL_CONTROL_RESET;
      st.cfg <= CFG_RESET;
      st.txd <= 1'b1;
      st.rxd_prev <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign txd = st.txd;
  assign rxd_out = st.rxd_out;
  assign rxd_oe = st.rxd_oe;
  assign serial_irq = st.irq;

  default clocking cb @(posedge pclk iff ce);
  endclocking
  default disable iff (!presetn);

  chk_serial_data_buffer_write_split: assert property (
    wr_serial_data_buffer && !rx_load && !m0_end |=> $stable(st.rx_serial_data_buffer))
    else $error("data buffer write changed the receive register");

  chk_write_starts_tx: assert property (
    wr_serial_data_buffer |=> (st.tx_busy || st.m0_busy) && !st.txd)
    else $error("data buffer write did not start a transfer");

  chk_tx_flag_sticky: assert property (
    st.serial_control[SC_TI] && !wr_serial_control |=> st.serial_control[SC_TI])
    else $error("transmit done flag cleared by hardware");

  chk_rx_flag_sticky: assert property (
    st.serial_control[SC_RI] && !wr_serial_control |=> st.serial_control[SC_RI])
    else $error("receive done flag cleared by hardware");

  chk_load_when_free: assert property (
    rx_final && st.serial_control[SC_RI] |=> $stable(st.rx_serial_data_buffer) || $past(m0_end))
    else $error("frame loaded over an unread byte");

  chk_filter_ninth: assert property (
    rx_final && st.serial_control[SC_SM2] && !rxd_in && !wr_serial_control
      |=> $stable(st.rx_serial_data_buffer) && $stable(st.serial_control[SC_RI]))
    else $error("filtered frame was accepted");

  chk_ren_blocks_rx: assert property (
    !st.serial_control[SC_REN] && !wr_serial_control |=> st.rx_state == RX_IDLE)
    else $error("receiver active with reception disabled");

  chk_irq_follows: assert property (
    st.cfg[CFG_IE] && st.serial_control[SC_RI] && !wr_serial_control && !wr
      |=> serial_irq)
    else $error("serial request missing while a flag is set");

  chk_sync_no_async: assert property (
    mode == MODE_SYNC |=> st.rx_state == RX_IDLE || wr_serial_control)
    else $error("asynchronous receiver ran in sync mode");

  chk_tx_frame_len: assert property (
    wr_serial_data_buffer && mode == MODE_UART8 |=> st.tx_len == LEN_10)
    else $error("mode 1 frame length wrong");

  chk_apb_answer: assert property (
    access && !st.pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle after access");
endmodule // serial_port

// [dv/uart_far_end.sv]
// Far-end serial device: sends and captures asynchronous frames
`timescale 1ns/100ps
module uart_far_end (
  input wire logic pclk,
  input wire logic txd,
  output logic line
);
  int bit_len = 32;
  logic [8:0] got_q[$];
  logic [8:0] v;

  initial begin
    line = 1'b1;
  end

  // Line rests high between frames, as a pulled-up receive pin would
  task automatic send(input logic [8:0] d, input int nb);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < nb; i++) begin
      line <= f[i];
      repeat (bit_len) @(posedge pclk);
    end
    // Released line returns high so the next start bit is an edge
    line <= 1'b1;
  endtask

  // Captures eight data bits and the ninth or stop bit at bit centres
  always begin
    @(negedge txd);
    repeat (bit_len / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_len) @(posedge pclk);
      v[i] = txd;
    end
    got_q.push_back(v);
  end
endmodule // uart_far_end

// [dv/serial_port_tb_top.sv]
// Bench for the serial port: APB driver, far-end model, checks
`timescale 1ns/100ps
module serial_port_tb_top;
  import serial_port_pkg::*;
  localparam logic [11:0] A_PC = {IDX_POWER_CONTROL, 2'b00};
  localparam logic [11:0] A_SC = {IDX_SERIAL_CONTROL, 2'b00};
  localparam logic [11:0] A_SD = {IDX_SERIAL_DATA, 2'b00};
  localparam logic [11:0] A_CF = {IDX_PORT_CONFIG, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_type apb_req = '0;
  logic pready, pslverr, rxd_out, rxd_oe, txd, serial_irq, line, err;
  logic [31:0] prdata, rd;
  logic [31:0] seed = 32'h0000004a;
  logic t2_ovf = 1'b1;
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] tx_q[$];
  logic [8:0] got;
  logic [7:0] b;

  always #12.5 pclk = ~pclk;

  serial_port uut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .apb_req(apb_req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .timer1_overflow(1'b1), .timer2_overflow(t2_ovf),
    .rxd_in(rxd_oe ? rxd_out : line), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd), .serial_irq(serial_irq));
  uart_far_end far (.pclk(pclk), .txd(txd), .line(line));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Request is held until the edge that sees pready high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                 pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      results();
    end
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Sends one frame each way at once; checks the captured byte
  task automatic frame(input int nb, input logic [8:0] r);
    seed = xs(seed);
    tx_q.push_back(seed[7:0]);
    fork
      far.send(r, nb);
      wr(A_SD, seed);
    join
    repeat (40) @(posedge pclk);
    chk(far.got_q.size(), 1);
    got = far.got_q.pop_front();
    chk({24'h0, got[7:0]}, {24'h0, tx_q.pop_front()});
  endtask

  task automatic results;
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is thirteen frames of a few hundred cycles
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    results();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(A_SC, {24'h0, SERIAL_CONTROL_RESET});
    rdc(A_PC, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(A_SC, 32'h50);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      b = seed[7:0];
      frame(10, {1'b1, b});
      rdc(A_SC, 32'h57);
      rdc(A_SD, {24'h0, b});
      wr(A_SC, 32'h50);
    end
    wr(A_SC, 32'h70);
    frame(10, {1'b0, ~b});
    rdc(A_SC, 32'h72);
    wr(A_SC, 32'h70);
    frame(10, {1'b1, ~b});
    rdc(A_SC, 32'h77);
    frame(10, {1'b1, 8'h3c});
    rdc(A_SD, {24'h0, ~b});
    wr(A_SC, 32'hd8);
    frame(11, {1'b1, b});
    chk({31'h0, got[8]}, 32'h1);
    rdc(A_SC, 32'hdf);
    wr(A_SC, 32'hf0);
    frame(11, {1'b0, ~b});
    chk({31'h0, got[8]}, 32'h0);
    rdc(A_SC, 32'hf2);
    wr(A_SC, 32'h40);
    frame(10, {1'b1, 8'h5a});
    rdc(A_SC, 32'h42);
    wr(A_PC, 32'h80);
    rdc(A_PC, 32'h80);
    wr(A_CF, 32'h4);
    wr(A_SC, 32'h50);
    far.bit_len = 16;
    frame(10, {1'b1, b});
    rdc(A_SC, 32'h57);
    chk({31'h0, serial_irq}, 32'h1);
    wr(A_SC, 32'h98);
    repeat (2) @(negedge pclk);
    chk({31'h0, serial_irq}, 32'h0);
    far.bit_len = 32;
    frame(11, {1'b1, b});
    rdc(A_SC, 32'h9f);
    wr(A_CF, 32'h5);
    wr(A_SC, 32'h98);
    far.bit_len = 16;
    frame(11, {1'b1, ~b});
    rdc(A_SC, 32'h9f);
    rdc(A_SD, {24'h0, ~b});
    // Timer 2 source ignores the doubling bit
    wr(A_CF, 32'h6);
    wr(A_SC, 32'h50);
    far.bit_len = 16;
    frame(10, {1'b1, b});
    rdc(A_SC, 32'h57);
    // Sync mode send last: the far end would take it for a frame
    wr(A_SC, 32'h0);
    seed = xs(seed);
    wr(A_SD, seed);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      got[i] = rxd_out;
    end
    chk({31'h0, rxd_oe}, 32'h1);
    chk({24'h0, got[7:0]}, {24'h0, seed[7:0]});
    repeat (20) @(posedge pclk);
    rdc(A_SC, 32'h02);
    results();
  end
endmodule // serial_port_tb_top
